// File: hw/sgen_top.sv
// Sound generator: APB registers, clock divider, tone and duration engine
module sgen_top
  import sgen_pkg::*;
#(
  parameter logic [3:0] SRC_FITTED = 4'hF,
  parameter int DMA_CHANNELS = 16
)(
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic [3:0] SRC_TICK,
  input wire logic DEBUG_HALT,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic BUZZER_OUT,
  output logic BUZZER_OUT_INVERTED,
  output logic IRQ,
  output logic [15:0] DMA_REQ
);
  // Division mask for source ticks, used only by the divider hit logic
  function automatic logic [9:0] div_mask(input logic [2:0] code);
    div_mask = 10'((16 << code) - 1);
  endfunction

  logic debug_run;
  logic [2:0] clock_divider;
  sgen_src_t clock_source;
  logic [3:0] tempo_duration;
  logic drive_mode;
  sgen_mode_t output_mode;
  logic stop_output;
  logic block_enable;
  sgen_note_t buffer;
  sgen_note_t act;
  sgen_state_t state;
  logic buffer_empty_flag;
  logic output_done_flag;
  logic [1:0] irq_enable;
  logic [15:0] empty_dma_request_enable;
  logic [9:0] div_cnt;
  logic [7:0] phase;
  logic [8:0] unit_cnt;
  logic [10:0] units;

  // APB decode; one wait state, so the write lands at the PREADY edge
  wire access = PSEL & PENABLE & ~PREADY;
  wire xfer = PSEL & PENABLE & PREADY;
  wire wr = xfer & PWRITE;
  wire a_clk = PADDR == OFS_CLK;
  wire a_sel = PADDR == OFS_SEL;
  wire a_ctl = PADDR == OFS_CTL;
  wire a_dat = PADDR == OFS_DAT;
  wire a_flg = PADDR == OFS_FLG;
  wire a_ie = PADDR == OFS_IE;
  wire a_dma = PADDR == OFS_DMA;
  wire mapped = a_clk | a_sel | a_ctl | a_dat | a_flg | a_ie | a_dma;
  wire data_wr = wr & a_dat & (PSTRB[1:0] == 2'h3);
  wire stop_req = wr & a_ctl & PWDATA[BIT_STOP];
  wire done_clr = wr & a_flg & PWDATA[BIT_DONE];
  wire clk_wr = wr & a_clk & ~block_enable;
  wire [1:0] new_src = PWDATA[1:0];
  wire busy = state == ST_PLAY;

  // Operating tick: selected source, divided, gated by enable and debug halt
  wire src_tick = SRC_TICK[clock_source] & SRC_FITTED[clock_source];
  wire slow_src = clock_source == SRC_LOW_XTAL || clock_source == SRC_EXT_CLK;
  wire div_ok = slow_src ? clock_divider == DIV_BY_ONE : clock_divider != DIV_BY_ONE;
  wire div_hit = slow_src | ((div_cnt & div_mask(clock_divider)) == div_mask(clock_divider));
  wire run = block_enable & ~(DEBUG_HALT & ~debug_run);
  wire op_tick = run & src_tick & div_ok & div_hit;

  // Tone period and duty; buzzer modes drop the top frequency bits
  wire melody = output_mode == MODE_MELODY;
  wire [7:0] freq = melody ? act.scale_frequency : {2'h0, act.scale_frequency[5:0]};
  wire [7:0] half = 8'(({1'b0, freq} + 9'h1) >> 1);
  wire tone = melody ? phase < half : phase < {2'h0, act.length_duty};

  // Note length in 512-tick units: (length+1)*(tempo+1) or one-shot tempo+1
  wire [10:0] mel_units = 11'(({5'h0, act.length_duty} + 11'h1) * ({7'h0, tempo_duration} + 11'h1));
  wire [10:0] target = melody ? mel_units : {7'h0, tempo_duration} + 11'h1;
  wire timed = melody | output_mode == MODE_ONESHOT;
  wire note_end = busy & op_tick & timed & unit_cnt == 9'(UNIT_TICKS - 1)
    & units == target - 11'h1;

  // Trigger: first start, end of a melody note, or refresh in continuous mode
  wire has_data = ~buffer_empty_flag;
  wire load = run & has_data & ~stop_output & ((op_tick & (~busy | ~timed))
    | (note_end & melody));
  wire end_out = busy & ((stop_output & op_tick) | ~block_enable
    | (note_end & ~(melody & has_data)));
  wire sgen_state_t next_state = load ? ST_PLAY : end_out ? ST_IDLE : state;

  // Pin levels; rest drives true pin low and inverted pin high
  wire resting = busy & melody & act.rest_select;
  wire next_out = busy & ~resting & tone;
  wire next_out_n = resting | (drive_mode ? ~next_out : 1'b0);
  wire [15:0] dma_mask = 16'((32'h1 << DMA_CHANNELS) - 1);
  wire [1:0] flags = {buffer_empty_flag, output_done_flag};

  // Read mux; reserved bits read zero
  logic [15:0] rd;
  always_comb
  begin
    rd = 16'h0000;
    unique case (1'b1)
      a_clk: rd = {7'h0, debug_run, 1'b0, clock_divider, 2'h0, clock_source};
      a_sel: rd = {4'h0, tempo_duration, 5'h0, drive_mode, output_mode};
      a_ctl: rd = {7'h0, stop_output, 7'h0, block_enable};
      a_dat: rd = buffer;
      a_flg: rd = {7'h0, busy, 6'h0, flags};
      a_ie: rd = {14'h0, irq_enable};
      a_dma: rd = empty_dma_request_enable;
      default: rd = 16'h0000;
    endcase
  end

  // Bus response flops
  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end
    else
    begin
      PREADY <= access;
      PSLVERR <= access & ~mapped;
      if (access)
        PRDATA <= {16'h0000, rd};
    end
  end

  // Clock control; unfitted sources keep the old choice
  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      debug_run <= 1'b0;
      clock_divider <= 3'h0;
      clock_source <= SRC_INT_OSC;
    end
    else if (clk_wr)
    begin
      debug_run <= PWDATA[BIT_DEBUG_RUN];
      clock_divider <= PWDATA[BIT_DIV_LO +: 3];
      if (SRC_FITTED[new_src])
        clock_source <= sgen_src_t'(new_src);
    end
  end

  // Mode select and control; reserved mode code is refused
  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      tempo_duration <= 4'h0;
      drive_mode <= 1'b0;
      output_mode <= MODE_CONT;
      block_enable <= 1'b0;
    end
    else
    begin
      if (wr & a_sel)
      begin
        tempo_duration <= PWDATA[BIT_TEMPO_LO +: 4];
        drive_mode <= PWDATA[BIT_DRIVE];
        if (PWDATA[1:0] != MODE_RSVD)
          output_mode <= sgen_mode_t'(PWDATA[1:0]);
      end
      if (wr & a_ctl)
        block_enable <= PWDATA[0];
    end
  end

  // Enables for events and DMA
  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      irq_enable <= 2'h0;
      empty_dma_request_enable <= RST_DMA;
    end
    else
    begin
      if (wr & a_ie)
        irq_enable <= PWDATA[1:0];
      if (wr & a_dma)
        empty_dma_request_enable <= PWDATA[15:0];
    end
  end

  // Sound buffer and active note
  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      buffer <= RST_DATA;
      act <= RST_DATA;
    end
    else
    begin
      if (data_wr)
        buffer <= PWDATA[15:0];
      if (load)
        act <= buffer;
    end
  end

  // Flags: a set in the same cycle as a clear wins
  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      buffer_empty_flag <= 1'b1;
      output_done_flag <= 1'b0;
      stop_output <= 1'b0;
      state <= ST_IDLE;
    end
    else
    begin
      buffer_empty_flag <= load | stop_req | (buffer_empty_flag & ~data_wr);
      output_done_flag <= end_out | (output_done_flag & ~done_clr & ~data_wr);
      stop_output <= stop_req | (stop_output & busy & ~end_out);
      state <= next_state;
    end
  end

  // Divider, tone phase and duration counters
  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      div_cnt <= 10'h000;
      phase <= 8'h00;
      unit_cnt <= 9'h000;
      units <= 11'h000;
    end
    else
    begin
      if (~block_enable)
        div_cnt <= 10'h000;
      else if (run & src_tick)
        div_cnt <= div_cnt + 10'h001;
      if (load & ~(melody & buffer.tie_slur))
        phase <= 8'h00;
      else if (op_tick)
        phase <= (phase >= freq) ? 8'h00 : phase + 8'h01;
      if (load)
      begin
        unit_cnt <= 9'h000;
        units <= 11'h000;
      end
      else if (op_tick & busy)
      begin
        unit_cnt <= unit_cnt + 9'h001;
        if (unit_cnt == 9'(UNIT_TICKS - 1))
          units <= units + 11'h001;
      end
    end
  end

  // Pins, interrupt and DMA requests, all registered
  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      BUZZER_OUT <= 1'b0;
      BUZZER_OUT_INVERTED <= 1'b0;
      IRQ <= 1'b0;
      DMA_REQ <= 16'h0000;
    end
    else
    begin
      BUZZER_OUT <= next_out;
      BUZZER_OUT_INVERTED <= next_out_n;
      IRQ <= |(flags & irq_enable);
      DMA_REQ <= {16{buffer_empty_flag}} & empty_dma_request_enable & dma_mask;
    end
  end

  // Checks
  a_load_sets_empty: assert property (@(posedge CLK_SYS) disable iff (RESET)
    load |=> buffer_empty_flag && busy) else $error("load did not set empty and busy");
  a_end_sets_done: assert property (@(posedge CLK_SYS) disable iff (RESET)
    end_out && !load |=> output_done_flag && !busy) else $error("end did not set done");
  a_clk_lock: assert property (@(posedge CLK_SYS) disable iff (RESET)
    block_enable |=> $stable(clock_divider) && $stable(clock_source))
    else $error("clock control changed while enabled");
  a_partial_ignored: assert property (@(posedge CLK_SYS) disable iff (RESET)
    wr && a_dat && PSTRB[1:0] != 2'h3 |=> $stable(buffer)) else $error("byte write took");
  a_irq_gate: assert property (@(posedge CLK_SYS) disable iff (RESET)
    ##1 IRQ == |($past(flags) & $past(irq_enable))) else $error("irq not gated");
  a_stop_empty: assert property (@(posedge CLK_SYS) disable iff (RESET)
    stop_req |=> buffer_empty_flag && stop_output) else $error("stop did not set empty");
  a_rest_pins: assert property (@(posedge CLK_SYS) disable iff (RESET)
    resting |=> !BUZZER_OUT && BUZZER_OUT_INVERTED) else $error("rest pins wrong");
  a_idle_quiet: assert property (@(posedge CLK_SYS) disable iff (RESET)
    !busy |=> !BUZZER_OUT) else $error("pin toggles while idle");
  a_off_no_tick: assert property (@(posedge CLK_SYS) disable iff (RESET)
    !block_enable |-> !op_tick ##1 !busy) else $error("ticks while disabled");
  a_data_clears: assert property (@(posedge CLK_SYS) disable iff (RESET)
    data_wr && !load && !stop_req |=> !buffer_empty_flag) else $error("empty not cleared");
endmodule

// File: pkg/sgen_pkg.sv
// Package for the sound generator: register map, fields, reset values, types
package sgen_pkg;
  // Register byte offsets on APB
  localparam logic [7:0] OFS_CLK = 8'h00;
  localparam logic [7:0] OFS_SEL = 8'h04;
  localparam logic [7:0] OFS_CTL = 8'h08;
  localparam logic [7:0] OFS_DAT = 8'h0C;
  localparam logic [7:0] OFS_FLG = 8'h10;
  localparam logic [7:0] OFS_IE = 8'h14;
  localparam logic [7:0] OFS_DMA = 8'h18;
  // Field positions
  localparam int BIT_DEBUG_RUN = 8;
  localparam int BIT_DIV_LO = 4;
  localparam int BIT_TEMPO_LO = 8;
  localparam int BIT_DRIVE = 2;
  localparam int BIT_STOP = 8;
  localparam int BIT_BUSY = 8;
  localparam int BIT_EMPTY = 1;
  localparam int BIT_DONE = 0;
  // Reset values
  localparam logic [15:0] RST_DATA = 16'h00FF;
  localparam logic [15:0] RST_DMA = 16'h0000;
  // Operating-clock ticks in one thirty-second note at tempo code 0
  localparam int UNIT_TICKS = 512;
  localparam logic [2:0] DIV_BY_ONE = 3'h7;
  // Clock sources
  typedef enum logic [1:0] {
    SRC_INT_OSC = 2'b00,
    SRC_LOW_XTAL = 2'b01,
    SRC_HIGH_OSC = 2'b10,
    SRC_EXT_CLK = 2'b11
  } sgen_src_t;
  // Sound output modes
  typedef enum logic [1:0] {
    MODE_CONT = 2'b00,
    MODE_ONESHOT = 2'b01,
    MODE_MELODY = 2'b10,
    MODE_RSVD = 2'b11
  } sgen_mode_t;
  // Output activity
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_PLAY = 1'b1
  } sgen_state_t;
  // One sound-buffer word
  typedef struct packed {
    logic tie_slur;
    logic rest_select;
    logic [5:0] length_duty;
    logic [7:0] scale_frequency;
  } sgen_note_t;
endpackage

// File: verification/sgen_buzzer_model.sv
// Listener model of the buzzer hanging on the two output pins
module sgen_buzzer_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  input wire logic pin_n,
  output int edges,
  output int clash
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last;
  // Tone cycles heard, and cycles with both pins high (would short the piezo)
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      last <= 1'b0;
      edges <= 0;
      clash <= 0;
    end
    else
    begin
      last <= pin;
      if (pin && !last)
        edges <= edges + 1;
      if (pin && pin_n)
        clash <= clash + 1;
    end
  end
endmodule

// File: verification/sgen_top_test.sv
// Self-checking testbench for the sound generator
module sgen_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import sgen_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic bz;
  logic bz_n;
  logic irq;
  logic [15:0] dma_req;
  logic [31:0] rd;
  logic er;
  int edges;
  int clash;
  int e0;
  int n_fail = 0;
  int comparisons = 0;

  // Free-running system clock, 10 ns period
  always #5 clk_sys = ~clk_sys;

  sgen_top sgen_top_inst (.CLK_SYS(clk_sys), .RESET(reset), .SRC_TICK(4'hF),
    .DEBUG_HALT(1'b0), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .BUZZER_OUT(bz), .BUZZER_OUT_INVERTED(bz_n), .IRQ(irq), .DMA_REQ(dma_req));

  sgen_buzzer_model sgen_buzzer_model_inst (.clk(clk_sys), .rst(reset), .pin(bz),
    .pin_n(bz_n), .edges(edges), .clash(clash));

  task automatic end_sim();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask

  // One APB transfer; request held until PREADY is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++)
      @(posedge clk_sys);
    if (n >= 20)
    begin
      chk("pready", 1, 0);
      end_sim();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(nm, e, rd);
  endtask

  // Poll busy until it drops; bounded so a stuck note ends the run
  task automatic wait_idle();
    int n;
    for (n = 0; n < 400; n++)
    begin
      apb(1'b0, OFS_FLG, 32'h0, 4'h0);
      if (rd[BIT_BUSY] === 1'b0)
        break;
    end
    if (n >= 400)
    begin
      chk("busy drop", 0, 1);
      end_sim();
    end
  endtask

  task automatic t_reset_and_bus();
    rchk("flags", OFS_FLG, 32'h2);
    rchk("data", OFS_DAT, {16'h0, RST_DATA});
    rchk("dma", OFS_DMA, {16'h0, RST_DMA});
    rchk("ctl", OFS_CTL, 32'h0);
    rchk("unmapped", 8'h1C, 32'h0);
    chk("slverr", 1, {31'h0, er});
  endtask

  // Slow source, divide by one: one op tick per system clock
  task automatic t_clock_and_mode();
    wr(OFS_CLK, 32'h71);
    wr(OFS_CTL, 32'h1);
    wr(OFS_CLK, 32'h0);
    rchk("clk locked", OFS_CLK, 32'h71);
    rchk("enable", OFS_CTL, 32'h1);
    wr(OFS_SEL, 32'h2);
    wr(OFS_SEL, 32'h3);
    rchk("mode", OFS_SEL, 32'h2);
    apb(1'b1, OFS_DAT, 32'h0, 4'h1);
    rchk("narrow", OFS_FLG, 32'h2);
  endtask

  task automatic t_melody_rest();
    wr(OFS_IE, 32'h3);
    wr(OFS_DMA, 32'h1);
    wr(OFS_CTL, 32'h0);
    wr(OFS_DAT, 32'h4000);
    rchk("written", OFS_FLG, 32'h0);
    chk("dma idle", 0, {16'h0, dma_req});
    wr(OFS_CTL, 32'h1);
    rchk("loaded", OFS_FLG, 32'h102);
    chk("dma", 1, {16'h0, dma_req});
    chk("irq", 1, {31'h0, irq});
    chk("rest pins", 1, {30'h0, bz, bz_n});
    wait_idle();
    chk("done", 3, rd);
    wr(OFS_FLG, 32'h0);
    rchk("done kept", OFS_FLG, 32'h3);
    wr(OFS_FLG, 32'h1);
    rchk("done clear", OFS_FLG, 32'h2);
    wr(OFS_IE, 32'h0);
    wr(OFS_DMA, 32'h0);
    chk("irq masked", 0, {31'h0, irq});
  endtask

  task automatic t_tone_stop();
    wr(OFS_SEL, 32'h4);
    wr(OFS_DAT, 32'h0509);
    e0 = edges;
    repeat (40) @(posedge clk_sys);
    chk("tone", 1, {31'h0, edges > e0});
    chk("complement", {31'h0, ~bz}, {31'h0, bz_n});
    wr(OFS_CTL, 32'h101);
    rchk("stopped", OFS_FLG, 32'h3);
    rchk("stop clear", OFS_CTL, 32'h1);
    chk("no clash", 0, clash);
  endtask

  // Divide-by-one on the fast internal source gives no ticks; one-shot then runs tempo+1 units and ends alone
  task automatic t_oneshot();
    wr(OFS_CTL, 32'h0);
    wr(OFS_CLK, 32'h70);
    wr(OFS_CTL, 32'h1);
    wr(OFS_SEL, 32'h101);
    wr(OFS_DAT, 32'h0509);
    repeat (40) @(posedge clk_sys);
    rchk("no tick", OFS_FLG, 32'h0);
    wr(OFS_CTL, 32'h0);
    wr(OFS_CLK, 32'h71);
    wr(OFS_CTL, 32'h1);
    repeat (2 * UNIT_TICKS - 100) @(posedge clk_sys);
    rchk("oneshot on", OFS_FLG, 32'h102);
    repeat (200) @(posedge clk_sys);
    rchk("oneshot end", OFS_FLG, 32'h3);
  endtask

  // Reset for six cycles, then the scenarios in order
  initial
  begin
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset_and_bus();
    t_clock_and_mode();
    t_melody_rest();
    t_tone_stop();
    t_oneshot();
    end_sim();
  end
endmodule
